// >>> inc/lgc_consts.vh
// Purpose: constants for the link group control register bank
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes: register indices are word indices; byte address is index times four
`ifndef LGC_CONSTS_VH
`define LGC_CONSTS_VH

// Register indices (word addressed)
`define LGC_IDX_POLICY 20'h3_0a03
`define LGC_IDX_RESYNC 20'h3_0a04
`define LGC_IDX_STATUS 20'h3_0a10
`define LGC_ADDR_W 22

// Reset values
`define LGC_RST_POLICY 8'h00
`define LGC_RST_RESYNC 8'h00

// Policy register fields
`define LGC_B_SUPPRESS 0
`define LGC_B_KEEP 1
`define LGC_B_REJOIN_A 3
`define LGC_B_REMOVE_A 4
`define LGC_B_REJOIN_B 6
`define LGC_B_REMOVE_B 7
`define LGC_POLICY_MASK 8'hdb

// Resync register fields
`define LGC_B_RESYNC_B 2
`define LGC_B_RESYNC_A 5
`define LGC_B_RESYNC_Q 7
`define LGC_RESYNC_MASK 8'ha4

// Event counts on a link
`define LGC_SEQ_COUNT 2'h3

// AXI responses
`define LGC_RESP_OKAY 2'h0
`define LGC_RESP_SLVERR 2'h2

`endif

// >>> design/lgc_link_mon.v
// Purpose: per-link receive health tracker for one SERDES channel
// Assumes: event inputs are one-cycle pulses on the core clock
// Notes: removal latches until frame loss or a rejoin run
`timescale 1ns/1ps
`include "lgc_consts.vh"

module lgc_link_mon (
  input wire clk_i,            // Core clock
  input wire rst_i,            // Async reset, active high
  input wire rejoin_i,         // Automatic rejoin enable
  input wire remove_i,         // Automatic remove enable
  input wire frame_lock_i,     // Frame acquired and stable
  input wire frame_bnd_i,      // Framing byte boundary pulse
  input wire seq_ok_i,         // Correct sequence number pulse
  input wire seq_exerr_i,      // Excessive sequence error pulse
  output reg link_ok_o,        // Receive link good
  output reg removed_o         // Link removed by sequence errors
);

  reg [1:0] err_cnt;
  reg [1:0] ok_cnt;

  // Error and good-sequence counters, removal latch, link state
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      err_cnt <= 2'h0;
      ok_cnt <= 2'h0;
      removed_o <= 1'b0;
      link_ok_o <= 1'b0;
    end else begin
      if (!frame_lock_i) begin
        // Frame loss restarts everything; may fall mid-frame
        err_cnt <= 2'h0;
        ok_cnt <= 2'h0;
        removed_o <= 1'b0;
        link_ok_o <= 1'b0;
      end else if (removed_o) begin
        // Rejoin only counts unbroken runs of correct numbers
        if (seq_exerr_i) begin
          ok_cnt <= 2'h0;
        end else if (seq_ok_i && rejoin_i) begin
          if (ok_cnt == `LGC_SEQ_COUNT - 2'h1) begin
            ok_cnt <= 2'h0;
            removed_o <= 1'b0;
          end else begin
            ok_cnt <= ok_cnt + 2'h1;
          end
        end
      end else begin
        ok_cnt <= 2'h0;
        if (seq_exerr_i && remove_i) begin
          if (err_cnt == `LGC_SEQ_COUNT - 2'h1) begin
            err_cnt <= 2'h0;
            removed_o <= 1'b1;
            link_ok_o <= 1'b0;
          end else begin
            err_cnt <= err_cnt + 2'h1;
          end
        end else if (frame_bnd_i) begin
          link_ok_o <= 1'b1;
        end
      end
    end
  end

endmodule

// >>> design/lgc_regs.v
// Purpose: link group policy and alignment resync register bank
// Assumes: AXI4-Lite slave, one write and one read outstanding at most
// Notes: links 0..3 are channels AC, AD (block A) and BC, BD (block B)
// Operation
// - Suppress on: transmit stops when paired receive link fails on sequence errors.
// - Suppress off: transmit continues despite excessive sequence errors.
// - Keep-active on: good links of a group keep delivering cell data.
// - Keep-active off: no cell data until every group link is good.
// - Rejoin on: link good returns after three consecutive correct sequences.
// - Auto-remove on: three excessive sequence errors drop link good.
// - Rising edge of block B pair control resyncs block B aligned channels.
// - Rising edge of block A pair control resyncs block A aligned channels.
// - Quad control resyncs all four channels set for alignment.
// - Link good rises only at framing boundary, may fall anytime.
// - Alignment sync status shows framing bytes detected per link.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "lgc_consts.vh"

module lgc_regs (
  input wire CORE_CLK_I,                    // Core clock, 100 MHz
  input wire RST_I,                         // Async reset, active high
  input wire [`LGC_ADDR_W-1:0] S_AXI_AWADDR_I, // Write address
  input wire S_AXI_AWVALID_I,               // Write address valid
  output reg S_AXI_AWREADY_O,               // Write address ready
  input wire [31:0] S_AXI_WDATA_I,          // Write data
  input wire [3:0] S_AXI_WSTRB_I,           // Write byte strobes
  input wire S_AXI_WVALID_I,                // Write data valid
  output reg S_AXI_WREADY_O,                // Write data ready
  output reg [1:0] S_AXI_BRESP_O,           // Write response
  output reg S_AXI_BVALID_O,                // Write response valid
  input wire S_AXI_BREADY_I,                // Write response ready
  input wire [`LGC_ADDR_W-1:0] S_AXI_ARADDR_I, // Read address
  input wire S_AXI_ARVALID_I,               // Read address valid
  output reg S_AXI_ARREADY_O,               // Read address ready
  output reg [31:0] S_AXI_RDATA_O,          // Read data
  output reg [1:0] S_AXI_RRESP_O,           // Read response
  output reg S_AXI_RVALID_O,                // Read data valid
  input wire S_AXI_RREADY_I,                // Read data ready
  input wire [3:0] FRAME_LOCK_I,            // Per-link frame acquired
  input wire [3:0] FRAME_BND_I,             // Per-link framing boundary pulse
  input wire [3:0] SEQ_OK_I,                // Per-link correct sequence pulse
  input wire [3:0] SEQ_EXERR_I,             // Per-link excessive seq error pulse
  input wire [3:0] ALIGN_BYTES_I,           // Per-link alignment bytes detected
  input wire [3:0] ALIGN_CFG_I,             // Per-link multi-channel alignment set
  output reg [3:0] TX_EN_O,                 // Per-link transmit allowed
  output reg [3:0] CELL_RD_EN_O,            // Per-link cell reader enable
  output reg [3:0] RX_LINK_OK_O,            // Per-link receive link good
  output reg [3:0] RESYNC_O                 // Per-channel resync pulse
);

  // Write channel state
  reg aw_held;
  reg w_held;
  reg [`LGC_ADDR_W-1:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  // Registers and history
  reg [7:0] link_group_policy;
  reg [7:0] alignment_resync_control;
  reg [7:0] resync_prev;
  // Resync pulse for the coming cycle
  reg [3:0] next_resync;
  wire [3:0] link_ok;
  wire [3:0] removed;
  wire [7:0] status_word;
  wire [3:0] resync_req;
  wire wr_go;
  wire [3:0] rejoin_en;
  wire [3:0] remove_en;

  // Word decode shared by read and write paths
  function [1:0] reg_sel;
    input [`LGC_ADDR_W-1:0] addr;
    begin
      if (addr[`LGC_ADDR_W-1:2] == `LGC_IDX_POLICY) begin
        reg_sel = 2'h1;
      end else if (addr[`LGC_ADDR_W-1:2] == `LGC_IDX_RESYNC) begin
        reg_sel = 2'h2;
      end else if (addr[`LGC_ADDR_W-1:2] == `LGC_IDX_STATUS) begin
        reg_sel = 2'h3;
      end else begin
        reg_sel = 2'h0;
      end
    end
  endfunction

  // Rising edge of one control bit against its previous value
  function rise_of;
    input now_v;
    input prev_v;
    begin
      rise_of = now_v & ~prev_v;
    end
  endfunction

  // Writable bits only; reserved bits always read back zero
  function [7:0] masked_byte;
    input [31:0] data;
    input [7:0] mask;
    begin
      masked_byte = data[7:0] & mask;
    end
  endfunction

  // Block A controls links 0..1, block B links 2..3
  assign rejoin_en = {{2{link_group_policy[`LGC_B_REJOIN_B]}},
                      {2{link_group_policy[`LGC_B_REJOIN_A]}}};
  assign remove_en = {{2{link_group_policy[`LGC_B_REMOVE_B]}},
                      {2{link_group_policy[`LGC_B_REMOVE_A]}}};

  // One tracker per link
  lgc_link_mon u_mon0 (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .rejoin_i(rejoin_en[0]),
    .remove_i(remove_en[0]),
    .frame_lock_i(FRAME_LOCK_I[0]),
    .frame_bnd_i(FRAME_BND_I[0]),
    .seq_ok_i(SEQ_OK_I[0]),
    .seq_exerr_i(SEQ_EXERR_I[0]),
    .link_ok_o(link_ok[0]),
    .removed_o(removed[0])
  );
  lgc_link_mon u_mon1 (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .rejoin_i(rejoin_en[1]),
    .remove_i(remove_en[1]),
    .frame_lock_i(FRAME_LOCK_I[1]),
    .frame_bnd_i(FRAME_BND_I[1]),
    .seq_ok_i(SEQ_OK_I[1]),
    .seq_exerr_i(SEQ_EXERR_I[1]),
    .link_ok_o(link_ok[1]),
    .removed_o(removed[1])
  );
  lgc_link_mon u_mon2 (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .rejoin_i(rejoin_en[2]),
    .remove_i(remove_en[2]),
    .frame_lock_i(FRAME_LOCK_I[2]),
    .frame_bnd_i(FRAME_BND_I[2]),
    .seq_ok_i(SEQ_OK_I[2]),
    .seq_exerr_i(SEQ_EXERR_I[2]),
    .link_ok_o(link_ok[2]),
    .removed_o(removed[2])
  );
  lgc_link_mon u_mon3 (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .rejoin_i(rejoin_en[3]),
    .remove_i(remove_en[3]),
    .frame_lock_i(FRAME_LOCK_I[3]),
    .frame_bnd_i(FRAME_BND_I[3]),
    .seq_ok_i(SEQ_OK_I[3]),
    .seq_exerr_i(SEQ_EXERR_I[3]),
    .link_ok_o(link_ok[3]),
    .removed_o(removed[3])
  );

  // Status: link good low nibble, alignment sync high nibble
  // Live view, not latched, so a read shows the current link state
  assign status_word = {ALIGN_BYTES_I, link_ok};

  // Rising edges only; a held 1 starts nothing further
  assign resync_req[1:0] =
    {2{rise_of(alignment_resync_control[`LGC_B_RESYNC_A],
               resync_prev[`LGC_B_RESYNC_A])}};
  assign resync_req[3:2] =
    {2{rise_of(alignment_resync_control[`LGC_B_RESYNC_B],
               resync_prev[`LGC_B_RESYNC_B])}};

  // Quad rise covers both pairs, so it takes priority
  always @* begin
    next_resync = resync_req & ALIGN_CFG_I;
    if (rise_of(alignment_resync_control[`LGC_B_RESYNC_Q],
                resync_prev[`LGC_B_RESYNC_Q])) begin
      next_resync = ALIGN_CFG_I;
    end
  end

  // A pending response blocks the next write, so no result is lost
  assign wr_go = aw_held && w_held && !S_AXI_BVALID_O;

  // Write channel: accept address and data in any order
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= {`LGC_ADDR_W{1'b0}};
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      S_AXI_AWREADY_O <= 1'b0;
      S_AXI_WREADY_O <= 1'b0;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= `LGC_RESP_OKAY;
      link_group_policy <= `LGC_RST_POLICY;
      alignment_resync_control <= `LGC_RST_RESYNC;
    end else begin
      // Ready pulses once per request, so a held valid is never taken twice
      S_AXI_AWREADY_O <= !aw_held && !S_AXI_AWREADY_O && S_AXI_AWVALID_I;
      S_AXI_WREADY_O <= !w_held && !S_AXI_WREADY_O && S_AXI_WVALID_I;
      if (S_AXI_AWREADY_O && S_AXI_AWVALID_I) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WREADY_O && S_AXI_WVALID_I) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA_I;
        w_strb <= S_AXI_WSTRB_I;
      end
      // Commit once both halves are in
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O <= `LGC_RESP_OKAY;
        // Unmapped words answer with an error and change nothing
        case (reg_sel(aw_addr))
          2'h1: begin
            if (w_strb[0]) begin
              link_group_policy <= masked_byte(w_data, `LGC_POLICY_MASK);
            end
          end
          2'h2: begin
            if (w_strb[0]) begin
              alignment_resync_control <= masked_byte(w_data, `LGC_RESYNC_MASK);
            end
          end
          2'h3: begin
            // Status is read only; write is dropped quietly
            S_AXI_BRESP_O <= `LGC_RESP_OKAY;
          end
          default: begin
            S_AXI_BRESP_O <= `LGC_RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
      end
    end
  end

  // Read channel: one-cycle ready, data the cycle after
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h0000_0000;
      S_AXI_RRESP_O <= `LGC_RESP_OKAY;
    end else begin
      // No new address while read data still waits for the master
      S_AXI_ARREADY_O <= !S_AXI_ARREADY_O && !S_AXI_RVALID_O && S_AXI_ARVALID_I;
      if (S_AXI_ARREADY_O && S_AXI_ARVALID_I) begin
        S_AXI_RVALID_O <= 1'b1;
        S_AXI_RRESP_O <= `LGC_RESP_OKAY;
        // Upper bits of every word read as zero
        case (reg_sel(S_AXI_ARADDR_I))
          2'h1: S_AXI_RDATA_O <= {24'h00_0000, link_group_policy};
          2'h2: S_AXI_RDATA_O <= {24'h00_0000, alignment_resync_control};
          2'h3: S_AXI_RDATA_O <= {24'h00_0000, status_word};
          default: begin
            S_AXI_RDATA_O <= 32'h0000_0000;
            S_AXI_RRESP_O <= `LGC_RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
        S_AXI_RVALID_O <= 1'b0;
      end
    end
  end

  // Link-facing outputs, all registered
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      resync_prev <= 8'h00;
      TX_EN_O <= 4'h0;
      CELL_RD_EN_O <= 4'h0;
      RX_LINK_OK_O <= 4'h0;
      RESYNC_O <= 4'h0;
    end else begin
      // Kept one cycle to find 0-to-1 writes
      resync_prev <= alignment_resync_control;
      // One cycle behind the trackers, like every link output
      RX_LINK_OK_O <= link_ok;
      // Transmit stops only when suppress set and partner removed
      if (link_group_policy[`LGC_B_SUPPRESS]) begin
        TX_EN_O <= ~removed;
      end else begin
        TX_EN_O <= 4'hf;
      end
      // Whole group must be good unless keep-active is set
      if (link_group_policy[`LGC_B_KEEP]) begin
        CELL_RD_EN_O <= link_ok;
      end else begin
        CELL_RD_EN_O <= {4{&link_ok}};
      end
      // Quad resync also edge driven, so a held bit is harmless
      RESYNC_O <= next_resync;
    end
  end

endmodule

// >>> tb/lgc_props.sv
// Purpose: port checks for the link group control register bank
// Assumes: one core clock, async active-high reset
// Notes: link outputs trail their link events by two cycles
`timescale 1ns/1ps
module lgc_props (
  input wire CORE_CLK_I, // Core clock
  input wire RST_I, // Reset
  input wire S_AXI_AWREADY_O, // Write address ready
  input wire S_AXI_WREADY_O, // Write data ready
  input wire [1:0] S_AXI_BRESP_O, // Write response
  input wire S_AXI_BVALID_O, // Write response valid
  input wire S_AXI_BREADY_I, // Write response ready
  input wire S_AXI_ARVALID_I, // Read address valid
  input wire S_AXI_ARREADY_O, // Read address ready
  input wire [31:0] S_AXI_RDATA_O, // Read data
  input wire S_AXI_RVALID_O, // Read data valid
  input wire S_AXI_RREADY_I, // Read data ready
  input wire [3:0] FRAME_LOCK_I, // Frame acquired
  input wire [3:0] FRAME_BND_I, // Framing boundary
  input wire [3:0] ALIGN_CFG_I, // Alignment configured
  input wire [3:0] TX_EN_O, // Transmit allowed
  input wire [3:0] CELL_RD_EN_O, // Cell reader enable
  input wire [3:0] RX_LINK_OK_O, // Link good
  input wire [3:0] RESYNC_O // Resync pulse
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  // Bus handshake timing
  property p_aw_pulse; S_AXI_AWREADY_O |=> !S_AXI_AWREADY_O; endproperty
  a_aw_pulse: assert property (p_aw_pulse) else $error("awready too long");
  property p_b_after; S_AXI_AWREADY_O && S_AXI_WREADY_O |-> ##2 S_AXI_BVALID_O; endproperty
  a_b_after: assert property (p_b_after) else $error("no write response");
  property p_b_hold;
    S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_lat; S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O; endproperty
  a_r_lat: assert property (p_r_lat) else $error("no read data");
  property p_r_hold;
    S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  // Resync pulses: single cycle, only on configured channels
  property p_rs_once; |RESYNC_O |=> RESYNC_O == 4'h0; endproperty
  a_rs_once: assert property (p_rs_once) else $error("resync repeated");
  property p_rs_cfg; (RESYNC_O & ~$past(ALIGN_CFG_I)) == 4'h0; endproperty
  a_rs_cfg: assert property (p_rs_cfg) else $error("resync unconfigured");
  // Link 0 good rises only two cycles after a boundary, and is low two cycles after lock loss
  property p_ok_rise; $rose(RX_LINK_OK_O[0]) |-> $past(FRAME_BND_I[0], 2); endproperty
  a_ok_rise: assert property (p_ok_rise) else $error("link good off boundary");
  property p_ok_lock; !FRAME_LOCK_I[0] |-> ##2 !RX_LINK_OK_O[0]; endproperty
  a_ok_lock: assert property (p_ok_lock) else $error("link good unlocked");
  // Cell reader never runs ahead of link good; a good link always has transmit allowed
  property p_cell_sub; (CELL_RD_EN_O & ~RX_LINK_OK_O) == 4'h0; endproperty
  a_cell_sub: assert property (p_cell_sub) else $error("reading bad link");
  property p_tx_ok; (RX_LINK_OK_O & ~TX_EN_O) == 4'h0; endproperty
  a_tx_ok: assert property (p_tx_ok) else $error("good link muted");
endmodule
bind lgc_regs lgc_props i_props (.*);

// >>> tb/lgc_link_src.sv
// Purpose: far-side framer model feeding link framing events
// Assumes: boundaries come every fourth core cycle
// Notes: unlocked links never show a boundary
`timescale 1ns/1ps
module lgc_link_src (
  input wire clk_i, // Core clock
  input wire rst_i, // Reset
  input wire [3:0] lock_i, // Frame acquired per link
  output reg [3:0] bnd_o, // Boundary pulse
  output wire [3:0] align_o // Alignment bytes seen
);
  reg [1:0] cnt;
  // Periodic boundary so link good can only rise on a frame edge
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 2'h0;
      bnd_o <= 4'h0;
    end else begin
      cnt <= cnt + 2'h1;
      bnd_o <= (cnt == 2'h3) ? lock_i : 4'h0;
    end
  end
  assign align_o = lock_i; // Framed links see alignment bytes
endmodule

// >>> tb/tb_link_group_control_regs.sv
// Purpose: self-checking bench for the link group control bank
// Assumes: AXI4-Lite master tasks, framer model on the link side
// Notes: seed fixed so every run repeats
`timescale 1ns/1ps
`include "lgc_consts.vh"
module tb_link_group_control_regs;
  localparam [21:0] A_POL = {`LGC_IDX_POLICY, 2'b00};
  localparam [21:0] A_RS = {`LGC_IDX_RESYNC, 2'b00};
  localparam [21:0] A_ST = {`LGC_IDX_STATUS, 2'b00};
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [21:0] awaddr = 22'h0, araddr = 22'h0;
  reg awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  reg [31:0] wdata = 32'h0, rd, v;
  reg [3:0] lock = 4'h0, seqok = 4'h0, exerr = 4'h0, cfg = 4'h0, seen;
  reg [3:0] strb = 4'hf;
  reg [1:0] rr;
  wire awr, wrd, bv, arr, rv;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] bnd, alg, txen, cren, ok, rs;
  integer mismatches = 0, cmp_count = 0, npl, i, b;
  always #5 clk = ~clk;
  lgc_link_src i_src (.clk_i(clk), .rst_i(rst), .lock_i(lock), .bnd_o(bnd), .align_o(alg));
  lgc_regs i_dut (.CORE_CLK_I(clk), .RST_I(rst), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(strb), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrd),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv),
    .S_AXI_RREADY_I(rready), .FRAME_LOCK_I(lock), .FRAME_BND_I(bnd), .SEQ_OK_I(seqok),
    .SEQ_EXERR_I(exerr), .ALIGN_BYTES_I(alg), .ALIGN_CFG_I(cfg), .TX_EN_O(txen),
    .CELL_RD_EN_O(cren), .RX_LINK_OK_O(ok), .RESYNC_O(rs));
  // Gather resync pulses between checks
  always @(posedge clk) if (rs != 4'h0) begin
    seen = seen | rs;
    npl = npl + 1;
  end
  task chk(input [31:0] g, input [31:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  // Write: address and data offered together, each dropped once taken
  task wr(input [21:0] a, input [31:0] d);
    reg da, dw;
    begin
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      da = 1'b0;
      dw = 1'b0;
      while (!(da && dw)) begin
        @(posedge clk);
        if (awr) begin awv <= 1'b0; da = 1'b1; end
        if (wrd) begin wv <= 1'b0; dw = 1'b1; end
      end
      while (bv !== 1'b1) @(posedge clk);
      rr = bresp;
      bready <= 1'b0;
    end
  endtask
  task rd_(input [21:0] a);
    begin
      @(posedge clk);
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      @(posedge clk);
      while (arr !== 1'b1) @(posedge clk);
      arv <= 1'b0;
      while (rv !== 1'b1) @(posedge clk);
      rd = rdata;
      rr = rresp;
      rready <= 1'b0;
    end
  endtask
  // Three spaced sequence events on the chosen links
  task pulses(input [3:0] m, input e);
    integer k;
    begin
      for (k = 0; k < 3; k = k + 1) begin
        @(posedge clk);
        if (e) exerr <= m; else seqok <= m;
        @(posedge clk);
        exerr <= 4'h0;
        seqok <= 4'h0;
      end
      repeat (6) @(posedge clk);
    end
  endtask
  function [7:0] exp_pol(input [31:0] d);
    exp_pol = d[7:0] & `LGC_POLICY_MASK;
  endfunction
  function [3:0] exp_rs(input integer bit_n, input [3:0] c);
    exp_rs = (bit_n == `LGC_B_RESYNC_A) ? (c & 4'h3) :
             (bit_n == `LGC_B_RESYNC_B) ? (c & 4'hc) : c;
  endfunction
  task close_out;
    begin
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #200000;
    mismatches = mismatches + 1;
    close_out;
  end
  initial begin
    i = $urandom(4534);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_(A_POL); chk(rd, 32'h0);
    rd_(A_RS); chk(rd, 32'h0);
    rd_(22'h00_0010); chk(rr, `LGC_RESP_SLVERR);
    chk(txen, 4'hf);
    // Random policy words read back through the field mask
    for (i = 0; i < 4; i = i + 1) begin
      v = $urandom;
      wr(A_POL, v); rd_(A_POL); chk(rd, exp_pol(v));
    end
    // Strobe off, status and unmapped writes: answer checked, nothing moves
    strb <= 4'h0;
    wr(A_POL, 32'h0000_00ff); chk(rr, `LGC_RESP_OKAY);
    strb <= 4'hf;
    wr(A_ST, 32'h0000_00ff); chk(rr, `LGC_RESP_OKAY);
    wr(22'h00_0010, 32'h0000_00ff); chk(rr, `LGC_RESP_SLVERR);
    rd_(A_POL); chk(rd, exp_pol(v));
    wr(A_POL, 32'h0000_0093);
    lock <= 4'hf;
    repeat (10) @(posedge clk);
    chk(ok, 4'hf);
    rd_(A_ST); chk(rd, 32'h0000_00ff);
    pulses(4'h1, 1'b1);
    chk(ok, 4'he);
    chk(txen, 4'he);
    chk(cren, 4'he);
    wr(A_POL, 32'h0000_0091); repeat (4) @(posedge clk); chk(cren, 4'h0);
    wr(A_POL, 32'h0000_0099); pulses(4'h1, 1'b0); chk(ok, 4'hf);
    // Suppress off, both blocks removing: transmit must stay up
    wr(A_POL, 32'h0000_0090); pulses(4'ha, 1'b1);
    chk(ok, 4'h5);
    chk(txen, 4'hf);
    // Each resync bit: rise, then hold at one
    v = $urandom;
    cfg <= v[3:0] | 4'h1;
    wr(A_RS, 32'h0);
    for (i = 0; i < 3; i = i + 1) begin
      b = (i == 0) ? `LGC_B_RESYNC_A : (i == 1) ? `LGC_B_RESYNC_B : `LGC_B_RESYNC_Q;
      @(negedge clk) seen = 4'h0;
      npl = 0;
      wr(A_RS, 32'h1 << b); wr(A_RS, 32'h1 << b);
      repeat (3) @(posedge clk);
      chk(seen, exp_rs(b, cfg));
      chk(npl, (exp_rs(b, cfg) != 4'h0) ? 1 : 0);
    end
    lock <= 4'h0;
    repeat (4) @(posedge clk);
    chk(ok, 4'h0);
    close_out;
  end
endmodule
